// ---- rtl/dso_pkg.sv ----
// constants and carrier types of the drive status output selector
package dso_pkg;

   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int NUM_OUT  = 4;
   localparam int NUM_USER = 2;
   localparam int NUM_ZONE = 8;
   localparam int NUM_NOTE = 8;

   // ----------------------------------------
   // assignment numbers
   // ----------------------------------------
   localparam logic [7:0] A_ANY_NOTICE_PRESENT       = 8'h87;
   localparam logic [7:0] A_ZONE0      = 8'hA0;
   localparam logic [7:0] A_ZONE7      = 8'hA7;
   localparam logic [7:0] A_MAIN_POWER = 8'hA8;
   localparam logic [7:0] A_BRAKE      = 8'hA9;
   localparam logic [7:0] A_REGEN      = 8'hAA;
   localparam logic [7:0] A_BOTH_OFF   = 8'hAC;
   localparam logic [7:0] A_ANY_OFF    = 8'hAD;
   localparam logic [7:0] A_USER0      = 8'hB4;
   localparam logic [7:0] A_CUR_LIM    = 8'hC0;
   localparam logic [7:0] A_SPD_LIM    = 8'hC1;
   localparam logic [7:0] A_PROFILE    = 8'hC4;
   localparam logic [7:0] A_LOST       = 8'hCB;
   localparam logic [7:0] A_DIRECT_CMD_READY   = 8'hCC;
   localparam logic [7:0] A_BUF_OCC    = 8'hCD;
   localparam logic [7:0] A_NOTE0      = 8'hE0;
   localparam logic [7:0] A_NOTE_SPD   = 8'hE8;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [11:0] OFS_SEL0   = 12'h000;
   localparam logic [11:0] OFS_USER0  = 12'h010;
   localparam logic [11:0] OFS_USER1  = 12'h014;
   localparam logic [11:0] OFS_STATUS = 12'h018;

   localparam int ST_LOST_BIT = 4;
   localparam int ST_OCC_BIT  = 5;
   localparam int ST_NOTE_BIT = 6;
   localparam int ST_PRA_BIT  = 7;
   localparam int ST_PRB_BIT  = 8;

   localparam logic [7:0] RST_SEL = 8'h00;

   // ----------------------------------------
   // carrier types
   // ----------------------------------------
   typedef struct packed {
      logic [NUM_ZONE-1:0] zone_inside;
      logic                main_power_present;
      logic                brake_released;
      logic                regen_active;
      logic                current_limited;
      logic                speed_limited;
      logic                internal_profile_running;
      logic                direct_cmd_ready;
      logic [NUM_NOTE-1:0] notice;
   } dso_cond_type;

   // bit 16 or_mode, bits 15:8 source b, bits 7:0 source a
   typedef struct packed {
      logic       or_mode;
      logic [7:0] src_b;
      logic [7:0] src_a;
   } dso_user_type;

   localparam dso_user_type RST_USER = '{or_mode: 1'b0, src_b: 8'h00, src_a: 8'h00};

endpackage

// ---- rtl/dso_top.sv ----
// drive status output selector with its apb register file
module dso_top
   import dso_pkg::*;
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire dso_cond_type       cond,
   input  wire logic               power_removal_in_a,
   input  wire logic               power_removal_in_b,
   input  wire logic               pulse_in,
   input  wire logic               pulse_enable,
   input  wire logic               setpoint_strobe,
   input  wire logic               profile_pos_mode,
   input  wire logic               buffer_taken,
   output logic      [NUM_OUT-1:0] status_out
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [2:0]          pra_sync;
   logic [2:0]          prb_sync;
   logic                pra;
   logic                prb;
   logic                next_pra;
   logic                next_prb;
   logic                lost;
   logic                next_lost;
   logic                occ;
   logic                next_occ;
   logic [7:0]          out_sel [NUM_OUT];
   logic [7:0]          next_out_sel [NUM_OUT];
   dso_user_type        user_cfg [NUM_USER];
   dso_user_type        next_user_cfg [NUM_USER];
   logic [31:0]         next_prdata;
   logic                next_pready;
   logic                next_pslverr;
   logic [NUM_OUT-1:0]  next_status_out;
   logic [255:0]        base;
   logic [255:0]        full;
   logic [NUM_USER-1:0] user_comb;
   logic                acc;
   logic                hit;
   logic                wr;
   logic                clr_lost;
   logic [31:0]         rd;

   // ----------------------------------------
   // power-removal input filters
   // ----------------------------------------
   always_comb begin
      next_pra = pra;
      next_prb = prb;
      if (pra_sync[1] == pra_sync[2]) begin
         next_pra = pra_sync[2];
      end
      if (prb_sync[1] == prb_sync[2]) begin
         next_prb = prb_sync[2];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pra_sync <= 3'h0;
         prb_sync <= 3'h0;
         pra      <= 1'b0;
         prb      <= 1'b0;
      end else begin
         pra_sync <= {pra_sync[1:0], power_removal_in_a};
         prb_sync <= {prb_sync[1:0], power_removal_in_b};
         pra      <= next_pra;
         prb      <= next_prb;
      end
   end

   // ----------------------------------------
   // source vector by assignment number
   // ----------------------------------------
   always_comb begin
      base = '0;
      base[A_ANY_NOTICE_PRESENT] = |cond.notice;
      for (int i = 0; i < NUM_ZONE; i++) begin
         base[A_ZONE0 + i] = cond.zone_inside[i];
      end
      base[A_MAIN_POWER] = cond.main_power_present;
      base[A_BRAKE] = cond.brake_released;
      base[A_REGEN] = cond.regen_active;
      base[A_BOTH_OFF] = ~pra & ~prb;
      base[A_ANY_OFF] = ~pra | ~prb;
      base[A_CUR_LIM] = cond.current_limited;
      base[A_SPD_LIM] = cond.speed_limited;
      base[A_PROFILE] = cond.internal_profile_running;
      base[A_LOST] = lost;
      base[A_DIRECT_CMD_READY] = cond.direct_cmd_ready;
      base[A_BUF_OCC] = occ;
      for (int i = 0; i < NUM_NOTE - 1; i++) begin
         base[A_NOTE0 + i] = cond.notice[i];
      end
      base[A_NOTE_SPD] = cond.notice[NUM_NOTE-1];
   end

   // user outputs draw on the base vector only, so they cannot loop
   generate
      for (genvar u = 0; u < NUM_USER; u++) begin : g_user
         always_comb begin
            if (user_cfg[u].or_mode) begin
               user_comb[u] = base[user_cfg[u].src_a] | base[user_cfg[u].src_b];
            end else begin
               user_comb[u] = base[user_cfg[u].src_a] & base[user_cfg[u].src_b];
            end
         end
      end
   endgenerate

   always_comb begin
      full = base;
      for (int u = 0; u < NUM_USER; u++) begin
         full[A_USER0 + u] = user_comb[u];
      end
   end

   // ----------------------------------------
   // flags and physical outputs
   // ----------------------------------------
   always_comb begin
      next_lost = (pulse_in & ~pulse_enable) | (lost & ~clr_lost);
      next_occ  = (setpoint_strobe & profile_pos_mode) | (occ & ~buffer_taken);
      for (int o = 0; o < NUM_OUT; o++) begin
         next_status_out[o] = full[out_sel[o]];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lost       <= 1'b0;
         occ        <= 1'b0;
         status_out <= '0;
      end else begin
         lost       <= next_lost;
         occ        <= next_occ;
         status_out <= next_status_out;
      end
   end

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   assign acc = psel & penable & ~pready;
   assign hit = (paddr[1:0] == 2'h0) && (paddr <= OFS_STATUS);
   assign wr  = psel & penable & pready & pwrite & ~pslverr;
   assign clr_lost = wr && (paddr == OFS_STATUS) && pwdata[ST_LOST_BIT];

   always_comb begin
      rd = '0;
      if (paddr < OFS_USER0) begin
         rd[7:0] = out_sel[paddr[3:2]];
      end else if (paddr == OFS_USER0) begin
         rd[16:0] = user_cfg[0];
      end else if (paddr == OFS_USER1) begin
         rd[16:0] = user_cfg[1];
      end else begin
         rd[NUM_OUT-1:0] = status_out;
         rd[ST_LOST_BIT] = lost;
         rd[ST_OCC_BIT]  = occ;
         rd[ST_NOTE_BIT] = base[A_ANY_NOTICE_PRESENT];
         rd[ST_PRA_BIT]  = pra;
         rd[ST_PRB_BIT]  = prb;
      end
   end

   always_comb begin
      next_pready  = acc;
      next_pslverr = acc & ~hit;
      next_prdata  = (acc && hit && !pwrite) ? rd : '0;
      next_out_sel  = out_sel;
      next_user_cfg = user_cfg;
      if (wr && paddr < OFS_USER0) begin
         next_out_sel[paddr[3:2]] = pwdata[7:0];
      end
      if (wr && paddr == OFS_USER0) begin
         next_user_cfg[0] = pwdata[16:0];
      end
      if (wr && paddr == OFS_USER1) begin
         next_user_cfg[1] = pwdata[16:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         for (int o = 0; o < NUM_OUT; o++) begin
            out_sel[o] <= RST_SEL;
         end
         for (int u = 0; u < NUM_USER; u++) begin
            user_cfg[u] <= RST_USER;
         end
      end else begin
         prdata   <= next_prdata;
         pready   <= next_pready;
         pslverr  <= next_pslverr;
         out_sel  <= next_out_sel;
         user_cfg <= next_user_cfg;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_zone_seven: assert property (@(posedge pclk) disable iff (!presetn)
      out_sel[0] == A_ZONE7 |=> status_out[0] == $past(cond.zone_inside[NUM_ZONE-1]))
      else $error("zone output does not follow zone state");

   a_main_power: assert property (@(posedge pclk) disable iff (!presetn)
      (out_sel[1] == A_MAIN_POWER) && !cond.main_power_present |=> !status_out[1])
      else $error("main power output high with power off");

   a_brake_out: assert property (@(posedge pclk) disable iff (!presetn)
      (out_sel[0] == A_BRAKE) && cond.brake_released |=> status_out[0])
      else $error("brake output low while released");

   a_regen_out: assert property (@(posedge pclk) disable iff (!presetn)
      (out_sel[2] == A_REGEN) |=> status_out[2] == $past(cond.regen_active))
      else $error("regen output wrong");

   a_both_off: assert property (@(posedge pclk) disable iff (!presetn)
      (out_sel[0] == A_BOTH_OFF) && (pra || prb) |=> !status_out[0])
      else $error("both-off monitor high with an input on");

   a_any_off: assert property (@(posedge pclk) disable iff (!presetn)
      (out_sel[1] == A_ANY_OFF) |=> status_out[1] == $past(!pra || !prb))
      else $error("any-off monitor wrong");

   a_user_and: assert property (@(posedge pclk) disable iff (!presetn)
      (out_sel[2] == A_USER0) && !user_cfg[0].or_mode && !base[user_cfg[0].src_a]
      |=> !status_out[2])
      else $error("user and output high with a source low");

   a_pulse_lost: assert property (@(posedge pclk) disable iff (!presetn)
      pulse_in && !pulse_enable |=> lost ##1 (lost || $past(clr_lost)))
      else $error("lost pulse flag not held");

   a_buf_fill: assert property (@(posedge pclk) disable iff (!presetn)
      setpoint_strobe && profile_pos_mode |=> occ)
      else $error("setpoint did not mark buffer occupied");

   a_buf_out: assert property (@(posedge pclk) disable iff (!presetn)
      (out_sel[2] == A_BUF_OCC) |=> status_out[2] == $past(occ))
      else $error("buffer output does not follow occupancy");

   a_note_speed: assert property (@(posedge pclk) disable iff (!presetn)
      (out_sel[3] == A_NOTE_SPD) |=> status_out[3] == $past(cond.notice[NUM_NOTE-1]))
      else $error("speed notice output wrong");

   a_any_notice: assert property (@(posedge pclk) disable iff (!presetn)
      (out_sel[1] == A_ANY_NOTICE_PRESENT) && (cond.notice != '0) |=> status_out[1])
      else $error("general notice output low with a notice present");

   a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pready |=> pready ##1 !pready)
      else $error("apb answer not one cycle into access");

   a_user_or: assert property (@(posedge pclk) disable iff (!presetn)
      (out_sel[3] == A_USER0 + 8'h01) && user_cfg[1].or_mode && base[user_cfg[1].src_b] |=> status_out[3])
      else $error("user or output low with a source high");

   a_cur_limit: assert property (@(posedge pclk) disable iff (!presetn)
      (out_sel[0] == A_CUR_LIM) |=> status_out[0] == $past(cond.current_limited))
      else $error("current limit output wrong");

   a_spd_limit: assert property (@(posedge pclk) disable iff (!presetn)
      (out_sel[1] == A_SPD_LIM) |=> status_out[1] == $past(cond.speed_limited))
      else $error("speed limit output wrong");

   a_profile_run: assert property (@(posedge pclk) disable iff (!presetn)
      (out_sel[2] == A_PROFILE) |=> status_out[2] == $past(cond.internal_profile_running))
      else $error("internal profile output wrong");

   a_cmd_ready: assert property (@(posedge pclk) disable iff (!presetn)
      (out_sel[3] == A_DIRECT_CMD_READY) |=> status_out[3] == $past(cond.direct_cmd_ready))
      else $error("direct command ready output wrong");

endmodule

// ---- verification/dso_host_model.sv ----
// host side model that issues set-of-setpoints strobes towards the selector
module dso_host_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic issue,
   output logic      setpoint_strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // one-cycle strobe per request
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         setpoint_strobe <= 1'b0;
      end else begin
         setpoint_strobe <= issue;
      end
   end
endmodule

// ---- verification/dso_top_test.sv ----
// self-checking testbench of the drive status output selector
module dso_top_test
   import dso_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic               pclk = 1'b0;
   logic               presetn = 1'b0;
   logic               psel = 1'b0;
   logic               penable = 1'b0;
   logic               pwrite = 1'b0;
   logic [11:0]        paddr = 12'h000;
   logic [31:0]        pwdata = 32'h0;
   logic [31:0]        prdata;
   logic               pready;
   logic               pslverr;
   dso_cond_type       cond = '0;
   logic               pra = 1'b1;
   logic               prb = 1'b1;
   logic               pulse_in = 1'b0;
   logic               pulse_en = 1'b1;
   logic               strobe;
   logic               issue = 1'b0;
   logic               pp_mode = 1'b0;
   logic               taken = 1'b0;
   logic [NUM_OUT-1:0] status_out;
   logic [31:0]        q;
   logic               err;
   logic [7:0]         codes[$];
   int                 miscompares = 0;
   int                 total_checks = 0;
   always #4 pclk = ~pclk;
   dso_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cond(cond),
      .power_removal_in_a(pra), .power_removal_in_b(prb), .pulse_in(pulse_in), .pulse_enable(pulse_en),
      .setpoint_strobe(strobe), .profile_pos_mode(pp_mode), .buffer_taken(taken), .status_out(status_out));
   dso_host_model i_host (.pclk(pclk), .presetn(presetn), .issue(issue), .setpoint_strobe(strobe));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         miscompares++;
         end_of_test();
      end
      // idle cycle keeps the next setup out of the release step
      @(posedge pclk);
   endtask
   task automatic edges(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic set_src(input logic [7:0] c, input logic v);
      case (c)
         A_MAIN_POWER: cond.main_power_present <= v;
         A_BRAKE:      cond.brake_released <= v;
         A_REGEN:      cond.regen_active <= v;
         A_CUR_LIM:    cond.current_limited <= v;
         A_SPD_LIM:    cond.speed_limited <= v;
         A_PROFILE:    cond.internal_profile_running <= v;
         A_DIRECT_CMD_READY:   cond.direct_cmd_ready <= v;
         A_ANY_NOTICE_PRESENT:       cond.notice[3] <= v;
         A_NOTE_SPD:   cond.notice[7] <= v;
         default: begin
            if (c >= A_ZONE0 && c <= A_ZONE7) cond.zone_inside[c - A_ZONE0] <= v;
            else cond.notice[c - A_NOTE0] <= v;
         end
      endcase
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      edges(3);
      presetn <= 1'b1;
      edges(1);
      apb(1'b0, OFS_SEL0, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, OFS_USER0, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(q, 32'h00000180);
      apb(1'b0, 12'h01C, 32'h0);
      chk({err, q}, {1'b1, 32'h0});
      codes = '{A_ANY_NOTICE_PRESENT, A_MAIN_POWER, A_BRAKE, A_REGEN, A_CUR_LIM, A_SPD_LIM, A_PROFILE, A_DIRECT_CMD_READY, A_NOTE_SPD};
      for (int i = 0; i < 8; i++) codes.push_back(A_ZONE0 + 8'(i));
      for (int i = 0; i < 7; i++) codes.push_back(A_NOTE0 + 8'(i));
      foreach (codes[k]) begin
         for (int s = 0; s < NUM_OUT; s++) begin
            apb(1'b1, OFS_SEL0 + 12'(4 * s), {24'h0, codes[k]});
         end
         set_src(codes[k], 1'b1);
         edges(2);
         chk(status_out, 4'hF);
         set_src(codes[k], 1'b0);
         edges(2);
         chk(status_out, 4'h0);
      end
      apb(1'b1, OFS_SEL0, {24'h0, A_BOTH_OFF});
      apb(1'b1, OFS_SEL0 + 12'h004, {24'h0, A_ANY_OFF});
      for (int i = 0; i < 4; i++) begin
         pra <= i[0];
         prb <= i[1];
         edges(8);
         chk(status_out[1:0], {~(i[0] & i[1]), ~(i[0] | i[1])});
      end
      apb(1'b1, OFS_SEL0 + 12'h008, {24'h0, A_USER0});
      apb(1'b1, OFS_SEL0 + 12'h00C, {24'h0, A_USER0 + 8'h01});
      apb(1'b1, OFS_USER0, {15'h0, 1'b0, A_BRAKE, A_MAIN_POWER});
      apb(1'b1, OFS_USER1, {15'h0, 1'b1, A_CUR_LIM, A_REGEN});
      for (int i = 0; i < 4; i++) begin
         cond.main_power_present <= i[0];
         cond.brake_released <= i[1];
         cond.regen_active <= i[0];
         cond.current_limited <= i[1];
         edges(3);
         chk(status_out[3:2], {i[0] | i[1], i[0] & i[1]});
      end
      apb(1'b1, OFS_SEL0, {24'h0, A_LOST});
      pulse_in <= 1'b1;
      edges(1);
      pulse_in <= 1'b0;
      edges(3);
      chk(status_out[0], 1'b0);
      pulse_en <= 1'b0;
      pulse_in <= 1'b1;
      edges(1);
      pulse_in <= 1'b0;
      edges(3);
      chk(status_out[0], 1'b1);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(q[ST_LOST_BIT], 1'b1);
      apb(1'b1, OFS_STATUS, 32'h10);
      edges(3);
      chk(status_out[0], 1'b0);
      apb(1'b1, OFS_SEL0 + 12'h008, {24'h0, A_BUF_OCC});
      for (int i = 0; i < 2; i++) begin
         pp_mode <= i[0];
         issue <= 1'b1;
         edges(1);
         issue <= 1'b0;
         edges(4);
         chk(status_out[2], i[0]);
      end
      taken <= 1'b1;
      edges(1);
      taken <= 1'b0;
      edges(3);
      chk(status_out[2], 1'b0);
      end_of_test();
   end
endmodule
